// >>> design/spaz_map.svh
// Constants for the sensor position and auto-zero block.
`ifndef SPAZ_MAP_SVH
`define SPAZ_MAP_SVH
`define SPAZ_QUAD_CPR        1024
`define SPAZ_QUAD_UNITS      4096
`define SPAZ_ROTOR_UNITS     2048
`define SPAZ_PWM_FULL_UNITS  4096
`define SPAZ_LOWRES_PULSES   20
`define SPAZ_LOWRES_UNITS    80
`define SPAZ_VEL_WINDOW_NS   100000000
`define SPAZ_CLK_PERIOD_NS   25
`define SPAZ_VEL_CYCLES      (`SPAZ_VEL_WINDOW_NS / `SPAZ_CLK_PERIOD_NS)
`define SPAZ_POS_RESET       32'h0000_0000
`endif

// >>> design/spaz_pkg.sv
// Types for the sensor position and auto-zero block.
package spaz_pkg;
	typedef enum logic [1:0] {
		SPAZ_SEL_QUAD,
		SPAZ_SEL_ROTOR,
		SPAZ_SEL_PWM,
		SPAZ_SEL_LOWRES
	} spaz_sel_e;
	typedef logic signed [31:0] spaz_pos_t;
endpackage : spaz_pkg

// >>> design/spaz_sync.sv
// Three-stage pin synchroniser with agreement qualification.
`timescale 1ns/1ps
module spaz_sync #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire logic             clk_en,
	// Raw pins
	input  wire logic [WIDTH-1:0] pins,
	// Qualified levels
	spaz_sync_if.src              sync
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
		logic [WIDTH-1:0] change;
	} spaz_sync_s;

	spaz_sync_s st;
	spaz_sync_s next_st;

	// The carrier bundle is six bits wide, so no other width can be served.
	if (WIDTH != 6) begin : g_bad_width
		$error("spaz_sync: width must be 6");
	end

	always_comb begin
		next_st = st;
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// A change counts once the second and third stages agree.
		next_st.change = (st.s2 ~^ st.s3) & (st.s3 ^ st.level);
		next_st.level = ((st.s2 ~^ st.s3) & st.s3) | (~(st.s2 ~^ st.s3) & st.level);
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign sync.level  = st.level;
	assign sync.change = st.change;
endmodule : spaz_sync

// >>> design/spaz_sync_if.sv
// Bundle of synchronised pin levels passed from the synchroniser to the top.
`timescale 1ns/1ps
interface spaz_sync_if;
	logic [5:0] level;
	logic [5:0] change;
	modport src (output level, output change);
	modport dst (input level, input change);
endinterface : spaz_sync_if

// >>> design/spaz_top.sv
// Sensor position, velocity and auto-zero logic.
`timescale 1ns/1ps
`include "spaz_map.svh"
//
// Function
// - Every rising and falling edge of both quadrature channels counts, giving 4096 units per turn of a 1024-cycle encoder.
// - The built-in rotor sensor is reported at 2048 units per rotation.
// - A pulse-width input is scaled so that full duty cycle equals 4096 units.
// - A 20-pulse low-resolution encoder yields 80 units per rotation by edge counting.
// - Position is reported in raw sensor units with no angle or distance conversion.
// - Velocity is the change of position in raw units over each 100 ms interval.
// - A host write overwrites the position of the currently selected sensor.
// - With auto-clear enabled for a source, its qualifying edge sets the selected position to zero.
// - A high-to-low transition on the forward limit clears position when enabled.
// - A high-to-low transition on the reverse limit clears position when enabled.
// - A low-to-high transition on the index input clears position when enabled.
module spaz_top #(
	parameter int VEL_CYCLES = `SPAZ_VEL_CYCLES,
	parameter int PWM_BITS   = 12
) (
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     nrst,
	input  wire logic                     clk_en,
	// Sensor pins
	input  wire logic                     quad_a,
	input  wire logic                     quad_b,
	input  wire logic                     quad_index,
	input  wire logic                     lowres_a,
	input  wire logic                     lowres_b,
	input  wire logic                     pwm_in,
	input  wire logic                     fwd_limit_input,
	input  wire logic                     rev_limit_input,
	// Built-in rotor sensor, same clock domain
	input  wire logic [10:0]              rotor_angle,
	// Configuration
	input  wire spaz_pkg::spaz_sel_e      sensor_sel,
	input  wire logic                     autoclear_fwd_enable,
	input  wire logic                     autoclear_rev_enable,
	input  wire logic                     autoclear_index_enable,
	input  wire logic                     cfg_strobe,
	// Host position write
	input  wire logic                     pos_wr,
	input  wire spaz_pkg::spaz_pos_t      pos_wr_data,
	// Results
	output spaz_pkg::spaz_pos_t           position,
	output spaz_pkg::spaz_pos_t           velocity,
	output logic                          velocity_valid,
	output logic [2:0]                    autoclear_status,
	output logic                          clear_event
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		spaz_pkg::spaz_pos_t quad_pos;
		spaz_pkg::spaz_pos_t low_pos;
		logic [10:0]         rotor_prev;
		spaz_pkg::spaz_pos_t rotor_pos;
		logic [PWM_BITS-1:0] pwm_high;
		logic [PWM_BITS-1:0] pwm_cnt;
		spaz_pkg::spaz_pos_t pwm_pos;
		logic [2:0]          en;
		logic [31:0]         vel_cnt;
		spaz_pkg::spaz_pos_t vel_base;
		spaz_pkg::spaz_pos_t velocity;
		logic                vel_valid;
		logic                clr;
	} spaz_top_s;

	spaz_top_s st;
	spaz_top_s next_st;
	spaz_sync_if sy ();

	// A window of one cycle would hold the valid pulse high without a break.
	if (VEL_CYCLES < 2) begin : g_bad_vel
		$error("spaz_top: VEL_CYCLES too small");
	end
	if (PWM_BITS < 2 || PWM_BITS > 16) begin : g_bad_pwm
		$error("spaz_top: PWM_BITS out of range");
	end

	spaz_sync #(.WIDTH(6)) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.clk_en  (clk_en),
		.pins    ({1'b0, rev_limit_input, fwd_limit_input, quad_index, quad_b, quad_a}),
		.sync    (sy.src)
	);

	// Separate synchroniser for the low-resolution pair and pulse-width pin.
	spaz_sync_if sy2 ();
	spaz_sync #(.WIDTH(6)) u_sync2 (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.clk_en  (clk_en),
		.pins    ({3'h0, pwm_in, lowres_b, lowres_a}),
		.sync    (sy2.src)
	);

	// ****************************************************************
	// Functions
	// ****************************************************************
	// Quadrature step from one qualified edge: +1, -1 or 0.
	function automatic logic signed [1:0] quad_step(input logic a, input logic b,
	                                                 input logic ca, input logic cb);
		logic signed [1:0] s;
		s = 2'sd0;
		if (ca) s = (a ^ b) ? -2'sd1 : 2'sd1;
		else if (cb) s = (a ^ b) ? 2'sd1 : -2'sd1;
		return s;
	endfunction : quad_step

	// Applies a step, a host write and a clear to one position.
	function automatic spaz_pkg::spaz_pos_t upd(input spaz_pkg::spaz_pos_t p,
	                                            input logic signed [31:0] d,
	                                            input logic sel, input logic wr,
	                                            input spaz_pkg::spaz_pos_t wd,
	                                            input logic clr);
		spaz_pkg::spaz_pos_t r;
		r = p + d;
		if (sel && wr) r = wd;
		if (sel && clr) r = '0;
		return r;
	endfunction : upd

	function automatic spaz_pkg::spaz_pos_t sel_pos(input spaz_top_s s,
	                                                input spaz_pkg::spaz_sel_e k);
		case (k)
			spaz_pkg::SPAZ_SEL_QUAD:   sel_pos = s.quad_pos;
			spaz_pkg::SPAZ_SEL_ROTOR:  sel_pos = s.rotor_pos;
			spaz_pkg::SPAZ_SEL_PWM:    sel_pos = s.pwm_pos;
			spaz_pkg::SPAZ_SEL_LOWRES: sel_pos = s.low_pos;
			default:                   sel_pos = s.quad_pos;
		endcase
	endfunction : sel_pos

	// ****************************************************************
	// Next state
	// ****************************************************************
	logic                clr_now;
	logic signed [31:0]  rotor_d;
	logic [31:0]         pwm_scaled;
	spaz_pkg::spaz_pos_t cur;

	always_comb begin
		next_st = st;
		if (cfg_strobe) begin
			next_st.en = {autoclear_index_enable, autoclear_rev_enable,
			              autoclear_fwd_enable};
		end
		// Falling limits and a rising index are the qualifying edges.
		clr_now = (st.en[0] && sy.change[3] && !sy.level[3])
		        | (st.en[1] && sy.change[4] && !sy.level[4])
		        | (st.en[2] && sy.change[2] &&  sy.level[2]);
		next_st.clr = clr_now;
		// Four edges per quadrature cycle on each counter.
		next_st.quad_pos = upd(st.quad_pos,
			32'(signed'(quad_step(sy.level[0], sy.level[1], sy.change[0], sy.change[1]))),
			sensor_sel == spaz_pkg::SPAZ_SEL_QUAD, pos_wr, pos_wr_data, clr_now);
		next_st.low_pos = upd(st.low_pos,
			32'(signed'(quad_step(sy2.level[0], sy2.level[1], sy2.change[0], sy2.change[1]))),
			sensor_sel == spaz_pkg::SPAZ_SEL_LOWRES, pos_wr, pos_wr_data, clr_now);
		// Rotor angle is 11 bits, so wrapping deltas keep 2048 per turn.
		next_st.rotor_prev = rotor_angle;
		rotor_d = 32'(signed'(rotor_angle - st.rotor_prev));
		next_st.rotor_pos = upd(st.rotor_pos, rotor_d,
			sensor_sel == spaz_pkg::SPAZ_SEL_ROTOR, pos_wr, pos_wr_data, clr_now);
		// Pulse width: count high and total cycles over one period.
		// The rising edge cycle itself opens the next period, so both counts start at one.
		// Periods longer than the counter span read as a steady level.
		pwm_scaled = 32'h0;
		next_st.pwm_cnt = st.pwm_cnt + 1'b1;
		if (sy2.level[2]) next_st.pwm_high = st.pwm_high + 1'b1;
		if (sy2.change[2] && sy2.level[2]) begin
			pwm_scaled = (32'(st.pwm_high) * 32'(`SPAZ_PWM_FULL_UNITS)) /
			             ((st.pwm_cnt == '0) ? 32'h1 : 32'(st.pwm_cnt));
			next_st.pwm_cnt = PWM_BITS'(1);
			next_st.pwm_high = PWM_BITS'(1);
			next_st.pwm_pos = pwm_scaled;
		end else if (st.pwm_cnt == '1) begin
			// No rising edge for a whole counter span: the duty is none or full.
			next_st.pwm_cnt = PWM_BITS'(1);
			next_st.pwm_high = PWM_BITS'(sy2.level[2]);
			next_st.pwm_pos = sy2.level[2] ? 32'(`SPAZ_PWM_FULL_UNITS) : 32'h0;
		end
		if (sensor_sel == spaz_pkg::SPAZ_SEL_PWM && pos_wr) next_st.pwm_pos = pos_wr_data;
		if (sensor_sel == spaz_pkg::SPAZ_SEL_PWM && clr_now) next_st.pwm_pos = '0;
		// Velocity as position change per window.
		cur = sel_pos(st, sensor_sel);
		next_st.vel_valid = 1'b0;
		if (st.vel_cnt == 32'(VEL_CYCLES - 1)) begin
			next_st.vel_cnt = 32'h0;
			next_st.velocity = cur - st.vel_base;
			next_st.vel_base = cur;
			next_st.vel_valid = 1'b1;
		end else begin
			next_st.vel_cnt = st.vel_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign position         = sel_pos(st, sensor_sel);
	assign velocity         = st.velocity;
	assign velocity_valid   = st.vel_valid;
	assign autoclear_status = st.en;
	assign clear_event      = st.clr;
endmodule : spaz_top

// >>> testbench/spaz_chk.sv
// Port assertions for the sensor position block.
`timescale 1ns/1ps
module spaz_chk #(
	parameter int VEL_CYCLES = 16
) (
	// Clock and reset
	input wire logic                clk_sys,
	input wire logic                nrst,
	input wire logic                clk_en,
	// Configuration and host write
	input wire spaz_pkg::spaz_sel_e sensor_sel,
	input wire logic                autoclear_fwd_enable,
	input wire logic                autoclear_rev_enable,
	input wire logic                autoclear_index_enable,
	input wire logic                cfg_strobe,
	input wire logic                pos_wr,
	input wire spaz_pkg::spaz_pos_t pos_wr_data,
	// Results
	input wire spaz_pkg::spaz_pos_t position,
	input wire logic                velocity_valid,
	input wire logic [2:0]          autoclear_status,
	input wire logic                clear_event
);
	// ****************************************
	// Helpers and assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic [2:0]  en_vec;
	int unsigned gap;
	logic        seen;
	assign en_vec = {autoclear_index_enable, autoclear_rev_enable, autoclear_fwd_enable};
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			gap  <= 0;
			seen <= 1'b0;
		end else if (velocity_valid) begin
			gap  <= 0;
			seen <= 1'b1;
		end else if (clk_en) begin
			gap  <= gap + 1;
		end
	end
	sequence s_cfg; cfg_strobe && clk_en; endsequence
	sequence s_wr; pos_wr && clk_en ##1 !clear_event && $stable(sensor_sel); endsequence
	a_cfg_status: assert property (s_cfg |=> autoclear_status == $past(en_vec))
		else $error("status differs from latched enables");
	a_status_hold: assert property (!(cfg_strobe && clk_en) |=> $stable(autoclear_status))
		else $error("status changed without strobe");
	a_wr_pos: assert property (s_wr |-> position == $past(pos_wr_data))
		else $error("written position not shown");
	a_clear_zero: assert property (clear_event |-> position == 32'h0)
		else $error("position not zero at clear");
	a_vel_single: assert property (velocity_valid && clk_en |=> !velocity_valid)
		else $error("velocity valid longer than one cycle");
	a_vel_period: assert property ($rose(velocity_valid) && seen |-> gap == VEL_CYCLES - 1)
		else $error("velocity window length wrong");
	a_freeze_pos: assert property (!clk_en ##1 $stable(sensor_sel) |-> $stable(position))
		else $error("position moved while frozen");
	a_no_clear: assert property ((autoclear_status == 3'h0) [*8] |-> !clear_event)
		else $error("clear with all sources disabled");
endmodule : spaz_chk
bind spaz_top spaz_chk #(.VEL_CYCLES(VEL_CYCLES)) u_chk (.clk_sys, .nrst, .clk_en, .sensor_sel,
	.autoclear_fwd_enable, .autoclear_rev_enable, .autoclear_index_enable, .cfg_strobe, .pos_wr,
	.pos_wr_data, .position, .velocity_valid, .autoclear_status, .clear_event);

// >>> testbench/spaz_sens_model.sv
// Encoder and limit switch model driving the sensor pins.
`timescale 1ns/1ps
module spaz_sens_model (
	// Clock
	input  wire logic clk_sys,
	// Sensor pins
	output logic      quad_a,
	output logic      quad_b,
	output logic      quad_index,
	output logic      lowres_a,
	output logic      lowres_b,
	output logic      fwd_limit_input,
	output logic      rev_limit_input,
	output logic      pwm_in
);
	// ****************************************
	// Pin stimulus
	// ****************************************
	int qs = 0;
	int ls = 0;
	initial begin
		{quad_a, quad_b, quad_index, lowres_a, lowres_b} = 5'h00;
		{fwd_limit_input, rev_limit_input} = 2'h3;
		pwm_in = 1'b0;
	end
	// Moves one encoder by n edges; B leads A for a positive count.
	task automatic step(input bit lowres, input int n);
		int d;
		d = (n < 0) ? 1 : 3;
		repeat ((n < 0) ? -n : n) begin
			@(posedge clk_sys);
			if (lowres) ls = (ls + d) % 4;
			else qs = (qs + d) % 4;
			{lowres_a, lowres_b} <= {ls[1] ^ ls[0], ls[1]};
			{quad_a, quad_b} <= {qs[1] ^ qs[0], qs[1]};
			repeat (7) @(posedge clk_sys);
		end
	endtask : step
	// Moves one pin away from its rest level and back; the return edge never clears.
	task automatic pulse(input int which);
		@(posedge clk_sys);
		if (which == 0) fwd_limit_input <= 1'b0;
		else if (which == 1) rev_limit_input <= 1'b0;
		else quad_index <= 1'b1;
		repeat (10) @(posedge clk_sys);
		{fwd_limit_input, rev_limit_input, quad_index} <= 3'h6;
		repeat (10) @(posedge clk_sys);
	endtask : pulse
	// Drives n pulse-width periods, then one more rising edge so the last one is measured.
	task automatic pwm(input int high, input int period, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			pwm_in <= 1'b1;
			repeat (high) @(posedge clk_sys);
			pwm_in <= 1'b0;
			repeat (period - high - 1) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		pwm_in <= 1'b1;
		repeat (8) @(posedge clk_sys);
		pwm_in <= 1'b0;
	endtask : pwm
	// Holds the pulse-width pin high for a number of cycles.
	task automatic hold_pwm(input int cycles);
		@(posedge clk_sys);
		pwm_in <= 1'b1;
		repeat (cycles) @(posedge clk_sys);
		pwm_in <= 1'b0;
	endtask : hold_pwm
endmodule : spaz_sens_model

// >>> testbench/testbench.sv
// Self-checking bench for the sensor position block.
`timescale 1ns/1ps
`include "spaz_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t got %h expected %h", $time, g, e); end end
module testbench;
	localparam int       VEL = 16;
	logic                clk_sys = 1'b0;
	logic [10:0]         rotor_angle = 11'h000;
	spaz_pkg::spaz_pos_t velocity;
	logic                velocity_valid;
	wire                 pwm_in;
	int                  ang = 0;
	logic                nrst = 1'b0;
	logic                clk_en = 1'b1;
	spaz_pkg::spaz_sel_e sensor_sel = spaz_pkg::SPAZ_SEL_QUAD;
	logic [2:0]          en = 3'h0;
	logic                cfg_strobe = 1'b0;
	logic                pos_wr = 1'b0;
	spaz_pkg::spaz_pos_t pos_wr_data = 32'h0;
	spaz_pkg::spaz_pos_t position;
	logic [2:0]          autoclear_status;
	logic                clear_event;
	wire                 quad_a, quad_b, quad_index, lowres_a, lowres_b;
	wire                 fwd_limit_input, rev_limit_input;
	int                  n_mismatch = 0;
	int                  n_checks = 0;
	int                  n_clr = 0;
	int                  n_exp = 0;
	int                  exp_p [4] = '{0, 0, 0, 0};
	// ****************************************
	// Instances and helpers
	// ****************************************
	spaz_top #(.VEL_CYCLES(VEL)) uut (.clk_sys, .nrst, .clk_en, .quad_a, .quad_b, .quad_index,
		.lowres_a, .lowres_b, .pwm_in, .fwd_limit_input, .rev_limit_input,
		.rotor_angle, .sensor_sel, .autoclear_fwd_enable(en[0]),
		.autoclear_rev_enable(en[1]), .autoclear_index_enable(en[2]), .cfg_strobe, .pos_wr,
		.pos_wr_data, .position, .velocity, .velocity_valid, .autoclear_status, .clear_event);
	spaz_sens_model sens (.clk_sys, .quad_a, .quad_b, .quad_index, .lowres_a, .lowres_b,
		.fwd_limit_input, .rev_limit_input, .pwm_in);
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (clear_event === 1'b1) n_clr++;
	task automatic chk_pos();
		@(negedge clk_sys);
		`CHK(position, 32'(exp_p[sensor_sel]))
	endtask : chk_pos
	task automatic cfg(input logic [2:0] v);
		@(posedge clk_sys);
		en <= v;
		cfg_strobe <= 1'b1;
		@(posedge clk_sys);
		cfg_strobe <= 1'b0;
		@(negedge clk_sys);
		`CHK(autoclear_status, v)
	endtask : cfg
	task automatic wr();
		spaz_pkg::spaz_pos_t d;
		d = $urandom;
		@(posedge clk_sys);
		pos_wr <= 1'b1;
		pos_wr_data <= d;
		@(posedge clk_sys);
		pos_wr <= 1'b0;
		exp_p[sensor_sel] = d;
		chk_pos();
	endtask : wr
	task automatic mv(input bit l, input int n);
		sens.step(l, n);
		exp_p[l ? 3 : 0] += n;
		chk_pos();
	endtask : mv
	task automatic src(input int i);
		sens.pulse(i);
		if (en[i]) begin
			exp_p[sensor_sel] = 0;
			n_exp++;
		end
		chk_pos();
	endtask : src
	// Steps the rotor angle; the 11-bit angle wraps while the position keeps counting.
	task automatic rot(input int n, input bit rnd);
		int s;
		repeat (n) begin
			s = rnd ? int'($urandom % 201) - 100 : 32;
			@(posedge clk_sys);
			ang = (ang + s) & 2047;
			rotor_angle <= 11'(ang);
			exp_p[1] += s;
		end
		@(posedge clk_sys);
		chk_pos();
	endtask : rot
	task automatic pw();
		int h;
		h = 1 + int'($urandom % 63);
		sens.pwm(h, 64, 3);
		exp_p[2] = h * `SPAZ_PWM_FULL_UNITS / 64;
		chk_pos();
	endtask : pw
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		#2000000;
		n_mismatch++;
		final_report();
	end
	initial begin
		void'($urandom(32'h93cacc56));
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk_pos();
		`CHK(autoclear_status, 3'h0)
		cfg(3'h5);
		mv(0, 4096);
		mv(0, -3);
		src(0);
		wr();
		src(1);
		cfg(3'h7);
		src(1);
		wr();
		src(2);
		@(posedge clk_sys);
		sensor_sel <= spaz_pkg::SPAZ_SEL_LOWRES;
		mv(1, 80);
		src(0);
		@(posedge clk_sys);
		clk_en <= 1'b0;
		pos_wr <= 1'b1;
		pos_wr_data <= $urandom;
		repeat (4) @(posedge clk_sys);
		clk_en <= 1'b1;
		pos_wr <= 1'b0;
		chk_pos();
		@(posedge clk_sys);
		sensor_sel <= spaz_pkg::SPAZ_SEL_ROTOR;
		fork
			rot(64, 1'b0);
			begin
				repeat (40) @(posedge clk_sys);
				@(negedge clk_sys iff velocity_valid === 1'b1);
				`CHK(velocity, 32'(VEL * 32))
			end
		join
		rot(50, 1'b1);
		@(posedge clk_sys);
		sensor_sel <= spaz_pkg::SPAZ_SEL_PWM;
		pw();
		sens.hold_pwm(4200);
		exp_p[2] = `SPAZ_PWM_FULL_UNITS;
		chk_pos();
		`CHK(n_clr, n_exp)
		final_report();
	end
endmodule : testbench
